// *** pkg/sivl_pkg.sv ***
/*
  Shared constants for the serial interface vector logic: bus widths,
  register offsets, field positions, reset values and vector codes.
  Assumes a 32-bit AHB-Lite register bus and a single 100 MHz clock.
*/
package sivl_pkg;

  localparam int unsigned HADDR_W  = 32;
  localparam int unsigned HDATA_W  = 32;
  localparam int unsigned OFS_W    = 5;
  localparam int unsigned SRC_N    = 4;
  localparam int unsigned VEC_W    = 5;
  localparam int unsigned LINE_N   = 2;

  // Register byte offsets
  localparam logic [OFS_W-1:0] OFS_VEC_LINE0 = 5'h00;
  localparam logic [OFS_W-1:0] OFS_VEC_LINE1 = 5'h04;
  localparam logic [OFS_W-1:0] OFS_FLAGS     = 5'h08;
  localparam logic [OFS_W-1:0] OFS_ENABLE    = 5'h0C;
  localparam logic [OFS_W-1:0] OFS_LINE_SEL  = 5'h10;

  // Source positions in flag, enable and line select, highest priority first
  localparam int unsigned SRC_ERR = 0;
  localparam int unsigned SRC_OVR = 1;
  localparam int unsigned SRC_RXF = 2;
  localparam int unsigned SRC_TXE = 3;

  // Vector field position inside a vector register
  localparam int unsigned VEC_LSB     = 1;
  localparam int unsigned VEC_MSB     = 5;
  localparam int unsigned SUSPEND_BIT = 0;

  // Reset values and clear masks
  localparam logic [SRC_N-1:0] FLAGS_RST    = 4'h0;
  localparam logic [SRC_N-1:0] ENABLE_RST   = 4'h0;
  localparam logic [SRC_N-1:0] LINE_SEL_RST = 4'h0;
  localparam logic [SRC_N-1:0] RD_CLR_MASK  = 4'h6;
  localparam logic [SRC_N-1:0] W1C_MASK     = 4'h7;

  typedef enum logic [VEC_W-1:0] {
    VEC_NONE       = 5'h00,
    VEC_ERROR      = 5'h11,
    VEC_RX_FULL    = 5'h12,
    VEC_RX_OVERRUN = 5'h13,
    VEC_TX_EMPTY   = 5'h14
  } sivl_vec_type;

endpackage

// *** logic/sivl_prio_enc.sv ***
/*
  Priority encoder for one interrupt line: turns the pending sources of
  the line into a vector code and a one-hot grant of the chosen source.
  Assumes pending bits are already gated by enable and line routing.
*/
`timescale 1ns/100ps
`default_nettype none

module sivl_prio_enc
  import sivl_pkg::*;
(
  input  wire logic [sivl_pkg::SRC_N-1:0] pend_i,
  output sivl_pkg::sivl_vec_type          code_o,
  output logic      [sivl_pkg::SRC_N-1:0] grant_o
);

  // Error, overrun, receive full, transmit empty, in that order
  always_comb begin
    code_o  = VEC_NONE;
    grant_o = '0;
    if (pend_i[SRC_ERR]) begin
      code_o           = VEC_ERROR;
      grant_o[SRC_ERR] = 1'b1;
    end else if (pend_i[SRC_OVR]) begin
      code_o           = VEC_RX_OVERRUN;
      grant_o[SRC_OVR] = 1'b1;
    end else if (pend_i[SRC_RXF]) begin
      code_o           = VEC_RX_FULL;
      grant_o[SRC_RXF] = 1'b1;
    end else if (pend_i[SRC_TXE]) begin
      code_o           = VEC_TX_EMPTY;
      grant_o[SRC_TXE] = 1'b1;
    end
  end

endmodule

`default_nettype wire

// *** logic/sivl_vector_top.sv ***
/*
  Interrupt vector logic of the serial interface: flag register, enable
  and line routing, two prioritised vector registers with read side
  effects, AHB-Lite slave and interrupt outputs.
  Assumes event inputs are single-cycle pulses from logic on SYS_CLK_I.
*/
`timescale 1ns/100ps
`default_nettype none

module sivl_vector_top
  import sivl_pkg::*;
(
  input  wire logic                         SYS_CLK_I,
  input  wire logic                         RESETN_I,
  input  wire logic                         HSEL_I,
  input  wire logic [sivl_pkg::HADDR_W-1:0] HADDR_I,
  input  wire logic [1:0]                   HTRANS_I,
  input  wire logic                         HWRITE_I,
  input  wire logic [2:0]                   HSIZE_I,
  input  wire logic [sivl_pkg::HDATA_W-1:0] HWDATA_I,
  input  wire logic                         HREADY_I,
  output logic                              HREADYOUT_O,
  output logic                              HRESP_O,
  output logic      [sivl_pkg::HDATA_W-1:0] HRDATA_O,
  input  wire logic                         ERR_EVENT_I,
  input  wire logic                         OVERRUN_EVENT_I,
  input  wire logic                         RX_FULL_EVENT_I,
  input  wire logic                         TX_EMPTY_EVENT_I,
  input  wire logic                         TX_DATA_WRITE_I,
  output logic                              IRQ_LINE_ZERO_O,
  output logic                              IRQ_LINE_ONE_O,
  output logic                              IRQ_O
);

  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RESETN_I);

  logic [SRC_N-1:0]   flags_q;
  logic [SRC_N-1:0]   flags_d;
  logic [SRC_N-1:0]   enable_q;
  logic [SRC_N-1:0]   line_sel_q;
  logic [SRC_N-1:0]   events;
  logic [SRC_N-1:0]   rd_clear;
  logic [SRC_N-1:0]   w1c_clear;
  logic [SRC_N-1:0]   pend     [LINE_N];
  logic [SRC_N-1:0]   grant    [LINE_N];
  sivl_vec_type       code     [LINE_N];
  logic               wr_pend_q;
  logic [OFS_W-1:0]   wr_ofs_q;
  logic               rd_data_q;
  logic [HDATA_W-1:0] rdata_q;
  logic [HDATA_W-1:0] rdata_d;
  logic               accept;
  logic               rd_accept;
  logic [OFS_W-1:0]   ofs;

  // Word-aligned register selection, shared by read and write paths
  function automatic logic hits(input logic [OFS_W-1:0] a,
                                input logic [OFS_W-1:0] target);
    hits = (a == target);
  endfunction

  function automatic logic [HDATA_W-1:0] vec_word(input sivl_vec_type c);
    vec_word = '0;
    vec_word[VEC_MSB:VEC_LSB] = c;
    vec_word[SUSPEND_BIT]     = 1'b0;
  endfunction

  assign ofs       = HADDR_I[OFS_W-1:0];
  assign accept    = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign rd_accept = accept & ~HWRITE_I;

  assign events[SRC_ERR] = ERR_EVENT_I;
  assign events[SRC_OVR] = OVERRUN_EVENT_I;
  assign events[SRC_RXF] = RX_FULL_EVENT_I;
  assign events[SRC_TXE] = TX_EMPTY_EVENT_I;

  // One encoder per line; sources routed by the line select bits
  generate
    for (genvar n = 0; n < LINE_N; n++) begin : g_line
      assign pend[n] = flags_q & enable_q &
                       ((n == 0) ? ~line_sel_q : line_sel_q);
      sivl_prio_enc u_enc (
        .pend_i  (pend[n]),
        .code_o  (code[n]),
        .grant_o (grant[n])
      );
    end
  endgenerate

  // Only overrun and receive full are cleared by reading their vector
  always_comb begin
    rd_clear = '0;
    if (rd_accept && hits(ofs, OFS_VEC_LINE0)) begin
      rd_clear = grant[0] & RD_CLR_MASK;
    end else if (rd_accept && hits(ofs, OFS_VEC_LINE1)) begin
      rd_clear = grant[1] & RD_CLR_MASK;
    end
  end

  // Software may clear error, overrun and receive full by writing one
  always_comb begin
    w1c_clear = '0;
    if (wr_pend_q && hits(wr_ofs_q, OFS_FLAGS)) begin
      w1c_clear = HWDATA_I[SRC_N-1:0] & W1C_MASK;
    end
  end

  // New events win over every clear in the same cycle
  always_comb begin
    flags_d = flags_q & ~rd_clear & ~w1c_clear;
    if (TX_DATA_WRITE_I) begin
      flags_d[SRC_TXE] = 1'b0;
    end
    flags_d = flags_d | events;
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Write address phase is held for the data phase
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q  <= '0;
    end else begin
      wr_pend_q <= accept & HWRITE_I;
      if (accept && HWRITE_I) begin
        wr_ofs_q <= ofs;
      end
    end
  end

  // Vector registers have no write path at all
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      enable_q   <= ENABLE_RST;
      line_sel_q <= LINE_SEL_RST;
    end else if (wr_pend_q) begin
      if (hits(wr_ofs_q, OFS_ENABLE)) begin
        enable_q <= HWDATA_I[SRC_N-1:0];
      end
      if (hits(wr_ofs_q, OFS_LINE_SEL)) begin
        line_sel_q <= HWDATA_I[SRC_N-1:0];
      end
    end
  end

  // Read data captured at the address phase edge, with its side effect
  always_comb begin
    rdata_d = '0;
    if (hits(ofs, OFS_VEC_LINE0)) begin
      rdata_d = vec_word(code[0]);
    end else if (hits(ofs, OFS_VEC_LINE1)) begin
      rdata_d = vec_word(code[1]);
    end else if (hits(ofs, OFS_FLAGS)) begin
      rdata_d[SRC_N-1:0] = flags_q;
    end else if (hits(ofs, OFS_ENABLE)) begin
      rdata_d[SRC_N-1:0] = enable_q;
    end else if (hits(ofs, OFS_LINE_SEL)) begin
      rdata_d[SRC_N-1:0] = line_sel_q;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rdata_q   <= '0;
      rd_data_q <= 1'b0;
    end else begin
      rd_data_q <= rd_accept;
      if (rd_accept) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign HRDATA_O    = rdata_q;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  assign IRQ_LINE_ZERO_O = (code[0] != VEC_NONE);
  assign IRQ_LINE_ONE_O  = (code[1] != VEC_NONE);
  assign IRQ_O           = |(flags_q & enable_q);

  a_vec_idle_zero: assert property (
    (pend[0] == '0) == (code[0] == VEC_NONE))
    else $error("line 0 vector not zero exactly when idle");

  a_vec_code_legal: assert property (
    code[1] inside {VEC_NONE, VEC_ERROR, VEC_RX_FULL,
                    VEC_RX_OVERRUN, VEC_TX_EMPTY})
    else $error("line 1 vector holds a reserved code");

  a_err_ranks_first: assert property (
    pend[1][SRC_ERR] |-> code[1] == VEC_ERROR)
    else $error("error not shown first on line 1");

  a_prio_order: assert property (
    (pend[0][SRC_RXF] && pend[0][SRC_TXE] &&
     !pend[0][SRC_ERR] && !pend[0][SRC_OVR]) |-> code[0] == VEC_RX_FULL)
    else $error("receive full not ranked above transmit empty");

  a_same_cycle_events: assert property (
    (OVERRUN_EVENT_I && RX_FULL_EVENT_I && !ERR_EVENT_I &&
     enable_q[SRC_OVR] && enable_q[SRC_RXF] &&
     !line_sel_q[SRC_OVR] && !line_sel_q[SRC_RXF] &&
     !flags_q[SRC_ERR] && !wr_pend_q) |=> code[0] == VEC_RX_OVERRUN)
    else $error("simultaneous events did not show overrun");

  a_rd_clear_full: assert property (
    (rd_accept && hits(ofs, OFS_VEC_LINE0) &&
     code[0] == VEC_RX_FULL && !RX_FULL_EVENT_I)
    |=> !flags_q[SRC_RXF] && rd_data_q &&
        HRDATA_O[VEC_MSB:VEC_LSB] == VEC_RX_FULL)
    else $error("receive full read did not clear its flag");

  a_rd_next_vector: assert property (
    (rd_accept && hits(ofs, OFS_VEC_LINE0) &&
     code[0] == VEC_RX_OVERRUN && !OVERRUN_EVENT_I &&
     pend[0] == 4'h2 && events == '0 && !wr_pend_q)
    |=> code[0] == VEC_NONE ##1
        (code[0] == VEC_NONE || $past(events) != '0 || $past(wr_pend_q)))
    else $error("vector did not advance after overrun read");

  a_rd_keep_txe: assert property (
    (rd_accept && code[1] == VEC_TX_EMPTY &&
     hits(ofs, OFS_VEC_LINE1) && !TX_DATA_WRITE_I &&
     events == '0 && !wr_pend_q)
    |=> flags_q[SRC_TXE] && code[1] == VEC_TX_EMPTY)
    else $error("transmit empty flag lost on vector read");

  a_txe_clear_write: assert property (
    (TX_DATA_WRITE_I && !TX_EMPTY_EVENT_I) |=> !flags_q[SRC_TXE])
    else $error("transmit data write did not clear empty flag");

  a_txe_holds: assert property (
    (flags_q[SRC_TXE] && !TX_DATA_WRITE_I) |=> flags_q[SRC_TXE])
    else $error("transmit empty flag cleared without data write");

  a_rd_keep_err: assert property (
    (rd_accept && hits(ofs, OFS_VEC_LINE0) && code[0] == VEC_ERROR &&
     !wr_pend_q)
    |=> flags_q[SRC_ERR] [*2])
    else $error("error flag cleared by vector read");

  a_vec_word_zero: assert property (
    rd_data_q && $past(hits(ofs, OFS_VEC_LINE1) ||
                       hits(ofs, OFS_VEC_LINE0))
    |-> HRDATA_O[HDATA_W-1:VEC_MSB+1] == '0 &&
        HRDATA_O[SUSPEND_BIT] == 1'b0)
    else $error("vector read shows nonzero reserved or suspend bits");

  a_vec_read_only: assert property (
    (wr_pend_q && (hits(wr_ofs_q, OFS_VEC_LINE0) ||
                   hits(wr_ofs_q, OFS_VEC_LINE1)) &&
     events == '0 && !TX_DATA_WRITE_I && !rd_accept)
    |=> flags_q == $past(flags_q) && enable_q == $past(enable_q) &&
        line_sel_q == $past(line_sel_q))
    else $error("write to a vector register changed state");

  a_line_route: assert property (
    (flags_q[SRC_ERR] && enable_q[SRC_ERR] && line_sel_q[SRC_ERR])
    |-> code[1] == VEC_ERROR && pend[0][SRC_ERR] == 1'b0)
    else $error("error source routed to the wrong line");

  a_code_rx_full: assert property (
    (pend[0][SRC_RXF] && !pend[0][SRC_ERR] && !pend[0][SRC_OVR])
    |-> code[0] == VEC_RX_FULL)
    else $error("receive full not encoded as its vector");

  a_code_tx_empty: assert property (
    (pend[1][SRC_TXE] && !pend[1][SRC_ERR] && !pend[1][SRC_OVR] &&
     !pend[1][SRC_RXF]) |-> code[1] == VEC_TX_EMPTY)
    else $error("transmit empty not encoded as its vector");

  a_ovr_over_rxf: assert property (
    (pend[1][SRC_OVR] && !pend[1][SRC_ERR])
    |-> code[1] == VEC_RX_OVERRUN)
    else $error("overrun not ranked above lower sources");

  a_err_event_live: assert property (
    (ERR_EVENT_I && enable_q[SRC_ERR] && !line_sel_q[SRC_ERR] &&
     !wr_pend_q) |=> code[0] == VEC_ERROR)
    else $error("error event not shown live on line 0");

  a_rd_clear_ovr: assert property (
    (rd_accept && hits(ofs, OFS_VEC_LINE1) &&
     code[1] == VEC_RX_OVERRUN && !OVERRUN_EVENT_I)
    |=> !flags_q[SRC_OVR])
    else $error("overrun read on line 1 did not clear its flag");

  a_rd_next_txe: assert property (
    (rd_accept && hits(ofs, OFS_VEC_LINE0) && code[0] == VEC_RX_FULL &&
     pend[0][SRC_TXE] && events == '0 && !TX_DATA_WRITE_I && !wr_pend_q)
    |=> code[0] == VEC_TX_EMPTY)
    else $error("vector did not advance to transmit empty");

  a_w1c_keeps_txe: assert property (
    (wr_pend_q && hits(wr_ofs_q, OFS_FLAGS) && flags_q[SRC_TXE] &&
     !TX_DATA_WRITE_I) |=> flags_q[SRC_TXE])
    else $error("flag write cleared transmit empty");

  a_err_kept_line1: assert property (
    (rd_accept && hits(ofs, OFS_VEC_LINE1) && code[1] == VEC_ERROR &&
     !wr_pend_q) |=> flags_q[SRC_ERR])
    else $error("error flag cleared by line 1 vector read");

  a_rd_data_line1: assert property (
    (rd_accept && hits(ofs, OFS_VEC_LINE1))
    |=> HRDATA_O[VEC_MSB:VEC_LSB] == $past(code[1]))
    else $error("line 1 register did not return line 1 vector");

  a_rd_upper_zero: assert property (
    rd_data_q |-> HRDATA_O[HDATA_W-1:VEC_MSB+1] == '0)
    else $error("read data shows nonzero upper bits");

  a_vec_write_rdata: assert property (
    (wr_pend_q && hits(wr_ofs_q, OFS_VEC_LINE0) && !rd_accept)
    |=> HRDATA_O == $past(HRDATA_O))
    else $error("write to vector register altered read data");

  a_same_edge_clear: assert property (
    (rd_accept && hits(ofs, OFS_VEC_LINE0) &&
     code[0] == VEC_RX_OVERRUN && !OVERRUN_EVENT_I)
    |=> !flags_q[SRC_OVR] && HRDATA_O[VEC_MSB:VEC_LSB] == VEC_RX_OVERRUN)
    else $error("overrun clear did not land with its read data");

endmodule

`default_nettype wire

// *** verif/sivl_vector_top_tb.sv ***
/*
  Self-checking bench for the serial interface vector logic.
  Assumes one AHB-Lite slave, hready looped back from hreadyout.
*/
`timescale 1ns/100ps
`default_nettype none

module sivl_vector_top_tb;
  import sivl_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hresp;
  logic        txw;
  logic        irq0;
  logic        irq1;
  logic        irq;
  logic        rd_dp = 1'b0;
  logic [1:0]  htrans;
  logic [3:0]  ev;
  logic [3:0]  flg;
  logic [3:0]  en;
  logic [3:0]  ls;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [31:0] exp_q[$];
  int          mismatches;
  int          n_checks;
  int          seed;
  int          i;

  sivl_vector_top sivl_vector_top_i (
    .SYS_CLK_I        (clk),
    .RESETN_I         (rst_n),
    .HSEL_I           (hsel),
    .HADDR_I          (haddr),
    .HTRANS_I         (htrans),
    .HWRITE_I         (hwrite),
    .HSIZE_I          (3'b010),
    .HWDATA_I         (hwdata),
    .HREADY_I         (hready),
    .HREADYOUT_O      (hready),
    .HRESP_O          (hresp),
    .HRDATA_O         (hrdata),
    .ERR_EVENT_I      (ev[SRC_ERR]),
    .OVERRUN_EVENT_I  (ev[SRC_OVR]),
    .RX_FULL_EVENT_I  (ev[SRC_RXF]),
    .TX_EMPTY_EVENT_I (ev[SRC_TXE]),
    .TX_DATA_WRITE_I  (txw),
    .IRQ_LINE_ZERO_O  (irq0),
    .IRQ_LINE_ONE_O   (irq1),
    .IRQ_O            (irq)
  );

  task automatic stop_test;
    if (exp_q.size() != 0) begin
      fail("notes left unread");
    end
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    mismatches++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail($sformatf("got %h expected %h", got, exp));
    end
  endtask

  // Expected read word from the bench's own flag, mask and routing copy
  function automatic logic [31:0] expv(input logic [31:0] a);
    logic [3:0] p;
    logic [4:0] c;
    p = 4'h0;
    case (a[4:0])
      OFS_FLAGS:     return {28'h000_0000, flg};
      OFS_ENABLE:    return {28'h000_0000, en};
      OFS_LINE_SEL:  return {28'h000_0000, ls};
      OFS_VEC_LINE0: p = flg & en & ~ls;
      OFS_VEC_LINE1: p = flg & en & ls;
      default:       return 32'h0000_0000;
    endcase
    c = p[SRC_ERR] ? VEC_ERROR : p[SRC_OVR] ? VEC_RX_OVERRUN :
        p[SRC_RXF] ? VEC_RX_FULL : p[SRC_TXE] ? VEC_TX_EMPTY : VEC_NONE;
    return {{26{1'b0}}, c, 1'b0};
  endfunction

  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      k++;
      if (k > 20) begin
        fail("bus timeout");
        stop_test();
      end
      @(posedge clk);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= a;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    case (a[4:0])
      OFS_FLAGS:    flg = flg & ~(d[3:0] & W1C_MASK);
      OFS_ENABLE:   en = d[3:0];
      OFS_LINE_SEL: ls = d[3:0];
      default:      ;
    endcase
  endtask

  task automatic rd(input logic [31:0] a);
    logic [31:0] e;
    e = expv(a);
    exp_q.push_back(e);
    if (a[4:0] == OFS_VEC_LINE0 || a[4:0] == OFS_VEC_LINE1) begin
      if (e[5:1] == VEC_RX_OVERRUN) flg[SRC_OVR] = 1'b0;
      if (e[5:1] == VEC_RX_FULL) flg[SRC_RXF] = 1'b0;
    end
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic pulse(input logic [3:0] m, input logic t);
    ev  <= m;
    txw <= t;
    @(posedge clk);
    ev  <= 4'h0;
    txw <= 1'b0;
    if (t) flg[SRC_TXE] = 1'b0;
    flg = flg | m;
    @(posedge clk);
  endtask

  task automatic chk_irq;
    #1;
    chk({28'h000_0000, hresp, irq, irq1, irq0},
        {28'h000_0000, 1'b0, |(flg & en), |(flg & en & ls),
         |(flg & en & ~ls)});
    @(posedge clk);
  endtask

  // Takes the oldest note when a read data phase completes
  always @(posedge clk) begin
    if (rd_dp && hready) begin
      if (exp_q.size() == 0) fail("read with no note");
      else chk(hrdata, exp_q.pop_front());
    end
    if (hready) rd_dp <= hsel && htrans[1] && !hwrite && rst_n;
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    ev = 4'h0;
    txw = 1'b0;
    flg = FLAGS_RST;
    en = ENABLE_RST;
    ls = LINE_SEL_RST;
    seed = 77;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 24; i += 4) rd(i);
    $display("test reset done");
    wr({27'h000_0000, OFS_ENABLE}, 32'h0000_000F);
    pulse(4'hF, 1'b0);
    chk_irq();
    rd(0);
    rd(0);
    wr({27'h000_0000, OFS_FLAGS}, 32'h0000_0001);
    for (i = 0; i < 4; i++) rd(0);
    chk_irq();
    pulse(4'h0, 1'b1);
    rd(0);
    $display("test priority done");
    wr({27'h000_0000, OFS_LINE_SEL}, 32'h0000_000A);
    pulse(4'hF, 1'b0);
    chk_irq();
    wr(0, 32'hFFFF_FFFF);
    wr(4, 32'hFFFF_FFFF);
    for (i = 0; i < 3; i++) rd(4);
    rd(0);
    $display("test routing done");
    for (i = 0; i < 60; i++) begin
      r = $random(seed);
      case (r[2:0])
        3'd0: wr({27'h000_0000, OFS_ENABLE}, r >> 4);
        3'd1: wr({27'h000_0000, OFS_LINE_SEL}, r >> 4);
        3'd2: wr({27'h000_0000, OFS_FLAGS}, r >> 4);
        3'd3: wr({{29{1'b0}}, r[3], 2'b00}, r);
        3'd4, 3'd5: pulse(r[7:4], r[8]);
        default: rd({{27{1'b0}}, r[5:3], 2'b00});
      endcase
      chk_irq();
    end
    $display("test random done");
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule

`default_nettype wire
